// ==== core/hbf_framer.sv ====
// HDLC bit-level framer with AHB-Lite register slave
`timescale 1ns/1ns
`include "hbf_cfg.svh"
module hbf_framer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic tx_clk_pin,
  input wire logic rx_clk_pin,
  input wire logic rx_data_pin,
  output logic tx_data_pin
);
  hbf_pkg::hbf_st_t st_ff;
  hbf_pkg::hbf_st_t nxt_st;
  logic [2:0] pins;
  logic tx_tick;
  logic rx_tick;
  logic rx_bit;
  logic rx_flag;
  logic rx_end;
  logic rx_abt;
  logic cnt_clr;

  assign pins = {rx_data_pin, rx_clk_pin, tx_clk_pin};
  // Line changes on falling link clock
  assign tx_tick = !st_ff.syn[0][1] && st_ff.syn[0][2];
  // Receive samples on rising link clock
  assign rx_tick = st_ff.syn[1][1] && !st_ff.syn[1][2];
  assign rx_bit = st_ff.syn[2][1];
  assign rx_flag = rx_tick && !rx_bit && (st_ff.rones == `HBF_ABT_N);
  assign rx_end = rx_flag && (st_ff.rxs == hbf_pkg::RX_FRAME) && st_ff.rany;
  assign rx_abt = rx_tick && rx_bit && (st_ff.rones == `HBF_ABT_N);
  assign cnt_clr = st_ff.pend && st_ff.wr && (st_ff.addr == `HBF_A_CNT);

  assign hreadyout = st_ff.rdy;
  assign hrdata = st_ff.rdata;
  assign hresp = st_ff.resp;
  assign tx_data_pin = st_ff.tline;

  // One LSB-first CRC-CCITT bit step
  function automatic logic [15:0] crc_step(
    input logic [15:0] c,
    input logic b
  );
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? `HBF_CRC_POLY : 16'h0000);
  endfunction

  // Register read mux
  function automatic logic [31:0] rd_reg(input hbf_pkg::hbf_st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (s.addr)
      `HBF_A_CTRL: r[4:0] = s.ctrl;
      `HBF_A_STAT: begin
        r[4:0] = s.stat;
        r[`HBF_S_TXB] = (s.txs != hbf_pkg::TX_IDLE);
        r[`HBF_S_RXF] = (s.rxs == hbf_pkg::RX_FRAME);
        r[`HBF_S_TXV] = s.txv;
      end
      `HBF_A_TXD: r[8:0] = s.txd;
      `HBF_A_RXD: begin
        r[7:0] = s.rxd;
        r[`HBF_D_VAL] = s.rxv;
      end
      `HBF_A_RES: r[2:0] = s.resid;
      `HBF_A_CNT: r[15:0] = s.ccnt;
      default: r = 32'h0000_0000;
    endcase
    rd_reg = r;
  endfunction

  always_comb begin
    logic [4:0] sset;
    logic [4:0] sclr;
    logic frm;
    logic ob;
    logic go_data;
    logic want_flag;
    logic [15:0] ncrc;
    sset = 5'h00;
    sclr = 5'h00;
    frm = 1'b0;
    ob = 1'b0;
    go_data = 1'b0;
    want_flag = 1'b0;
    ncrc = 16'h0000;
    nxt_st = st_ff;
    // Pin synchronisers
    for (int i = 0; i < 3; i++) begin
      nxt_st.syn[i] = {st_ff.syn[i][1:0], pins[i]};
    end

    // Bus slave, one wait state per transfer
    nxt_st.resp = 1'b0;
    if (st_ff.pend) begin
      nxt_st.pend = 1'b0;
      nxt_st.rdy = 1'b1;
      if (st_ff.wr) begin
        case (st_ff.addr)
          `HBF_A_CTRL: nxt_st.ctrl = hwdata[4:0];
          `HBF_A_STAT: sclr = hwdata[4:0];
          `HBF_A_TXD: begin
            if (!st_ff.txv) begin
              nxt_st.txd = hwdata[8:0];
              nxt_st.txv = 1'b1;
            end
          end
          `HBF_A_CNT: nxt_st.ccnt = 16'h0000;
          default: ;
        endcase
      end else begin
        nxt_st.rdata = rd_reg(st_ff);
        if (st_ff.addr == `HBF_A_RXD) begin
          nxt_st.rxv = 1'b0;
        end
      end
    end else if (hsel && htrans[1] && hready) begin
      nxt_st.pend = 1'b1;
      nxt_st.rdy = 1'b0;
      nxt_st.addr = haddr[7:0];
      nxt_st.wr = hwrite;
    end

    // Transmitter
    want_flag = st_ff.ctrl[`HBF_C_EN] && (st_ff.txv ||
      (st_ff.ctrl[`HBF_C_FILL] && !st_ff.ctrl[`HBF_C_DCH]));
    frm = (st_ff.txs == hbf_pkg::TX_DATA) || (st_ff.txs == hbf_pkg::TX_CRC);
    if (tx_tick) begin
      if (frm && !st_ff.ctrl[`HBF_C_EN]) begin
        nxt_st.txs = hbf_pkg::TX_ABORT;
        nxt_st.tsh = {8'h00, `HBF_MARKS};
        nxt_st.tcnt = `HBF_BYTE_BITS;
        nxt_st.tline = 1'b1;
        nxt_st.tones = 3'd0;
      end else if (st_ff.txs == hbf_pkg::TX_IDLE) begin
        nxt_st.tline = 1'b1;
        if (want_flag) begin
          nxt_st.txs = hbf_pkg::TX_FLAG1;
          nxt_st.tsh = {8'h00, `HBF_FLAG};
          nxt_st.tcnt = `HBF_BYTE_BITS;
        end
      end else if (st_ff.tones == `HBF_STUFF_N) begin
        nxt_st.tline = 1'b0;
        nxt_st.tones = 3'd0;
      end else begin
        ob = st_ff.tsh[0];
        nxt_st.tline = ob;
        nxt_st.tsh = {1'b0, st_ff.tsh[15:1]};
        nxt_st.tcnt = st_ff.tcnt - 5'd1;
        ncrc = crc_step(st_ff.tcrc, ob);
        if (st_ff.txs == hbf_pkg::TX_DATA) begin
          nxt_st.tcrc = ncrc;
        end
        nxt_st.tones = (frm && ob) ? st_ff.tones + 3'd1 : 3'd0;
        if (st_ff.tcnt == 5'd1) begin
          case (st_ff.txs)
            hbf_pkg::TX_DATA: begin
              if (st_ff.teof) begin
                nxt_st.txs = hbf_pkg::TX_CRC;
                nxt_st.tsh = ~ncrc ^ {15'h0000, st_ff.ctrl[`HBF_C_FCE]};
                nxt_st.tcnt = `HBF_CRC_BITS;
              end else if (st_ff.txv) begin
                go_data = 1'b1;
              end else begin
                nxt_st.txs = hbf_pkg::TX_ABORT;
                nxt_st.tsh = {8'h00, `HBF_MARKS};
                nxt_st.tcnt = `HBF_BYTE_BITS;
                sset[`HBF_S_UND] = 1'b1;
              end
            end
            hbf_pkg::TX_CRC: begin
              nxt_st.txs = hbf_pkg::TX_FLAG2;
              nxt_st.tsh = {8'h00, `HBF_FLAG};
              nxt_st.tcnt = `HBF_BYTE_BITS;
            end
            default: begin
              if ((st_ff.txs != hbf_pkg::TX_ABORT) && st_ff.ctrl[`HBF_C_EN] &&
                  st_ff.txv) begin
                go_data = 1'b1;
                nxt_st.tcrc = `HBF_CRC_INIT;
              end else if (want_flag) begin
                nxt_st.txs = hbf_pkg::TX_FLAG1;
                nxt_st.tsh = {8'h00, `HBF_FLAG};
                nxt_st.tcnt = `HBF_BYTE_BITS;
              end else begin
                nxt_st.txs = hbf_pkg::TX_IDLE;
              end
            end
          endcase
          if (go_data) begin
            nxt_st.txs = hbf_pkg::TX_DATA;
            nxt_st.tsh = {8'h00, st_ff.txd[7:0]};
            nxt_st.teof = st_ff.txd[8];
            nxt_st.txv = 1'b0;
            nxt_st.tcnt = `HBF_BYTE_BITS;
          end
        end
      end
    end

    // Receiver
    if (rx_tick) begin
      frm = 1'b0;
      if (rx_bit) begin
        nxt_st.rones = (st_ff.rones == `HBF_ONES_MAX) ? `HBF_ONES_MAX :
          st_ff.rones + 3'd1;
        if (rx_abt) begin
          if (st_ff.rxs == hbf_pkg::RX_FRAME) begin
            sset[`HBF_S_ABT] = 1'b1;
            nxt_st.rxv = 1'b0;
          end
          nxt_st.rxs = hbf_pkg::RX_HUNT;
          nxt_st.rany = 1'b0;
        end else if (st_ff.rones < `HBF_ABT_N) begin
          frm = 1'b1;
        end
      end else begin
        nxt_st.rones = 3'd0;
        if (rx_flag) begin
          if (rx_end) begin
            nxt_st.resid = st_ff.rbits;
            if (st_ff.rbits != 3'd0) begin
              nxt_st.rxd = st_ff.rsh >> (4'd8 - {1'b0, st_ff.rbits});
              nxt_st.rxv = 1'b1;
            end
            if (st_ff.rcrc == `HBF_CRC_GOOD) begin
              sset[`HBF_S_EOF] = 1'b1;
            end else begin
              nxt_st.ccnt = nxt_st.ccnt + 16'h0001;
              sset[`HBF_S_CRC] = 1'b1;
              if (st_ff.ctrl[`HBF_C_DISC]) begin
                nxt_st.rxv = 1'b0;
                sset[`HBF_S_DROP] = 1'b1;
              end else begin
                sset[`HBF_S_EOF] = 1'b1;
              end
            end
          end
          nxt_st.rxs = hbf_pkg::RX_FRAME;
          nxt_st.rcrc = `HBF_CRC_INIT;
          nxt_st.rdn = 3'd0;
          nxt_st.rbits = 3'd0;
          nxt_st.rany = 1'b0;
        end else if (st_ff.rones != `HBF_STUFF_N) begin
          frm = 1'b1;
        end
      end
      // Seven-bit hold-back keeps delimiter bits out of the data
      if (frm && (st_ff.rxs == hbf_pkg::RX_FRAME)) begin
        nxt_st.rdl = {rx_bit, st_ff.rdl[6:1]};
        if (st_ff.rdn == `HBF_DLY) begin
          ob = st_ff.rdl[0];
          nxt_st.rcrc = crc_step(st_ff.rcrc, ob);
          nxt_st.rsh = {ob, st_ff.rsh[7:1]};
          nxt_st.rbits = st_ff.rbits + 3'd1;
          nxt_st.rany = 1'b1;
          if (st_ff.rbits == 3'd7) begin
            nxt_st.rxd = {ob, st_ff.rsh[7:1]};
            nxt_st.rxv = 1'b1;
          end
        end else begin
          nxt_st.rdn = st_ff.rdn + 3'd1;
        end
      end
    end

    // Sticky status, set beats clear
    nxt_st.stat = (st_ff.stat & ~sclr) | sset;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.rdy <= 1'b1;
      st_ff.tline <= 1'b1;
      st_ff.txs <= hbf_pkg::TX_IDLE;
      st_ff.rxs <= hbf_pkg::RX_HUNT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  bus_wait_a: assert property (
    hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout
  ) else $error("bus answer not after one wait state");

  tx_flag_a: assert property (
    (st_ff.txs != $past(st_ff.txs)) && ((st_ff.txs == hbf_pkg::TX_FLAG1) ||
      (st_ff.txs == hbf_pkg::TX_FLAG2)) |-> st_ff.tsh[7:0] == `HBF_FLAG
  ) else $error("delimiter not loaded");

  tx_stuff_a: assert property (
    tx_tick && st_ff.ctrl[`HBF_C_EN] && (st_ff.tones == `HBF_STUFF_N) &&
      (st_ff.txs != hbf_pkg::TX_IDLE)
      |=> !tx_data_pin
  ) else $error("no zero after five ones");

  tx_hold_a: assert property (
    !tx_tick |=> $stable(tx_data_pin)
  ) else $error("line changed without link clock edge");

  tx_under_a: assert property (
    tx_tick && (st_ff.txs == hbf_pkg::TX_DATA) && (st_ff.tcnt == 5'd1) &&
      (st_ff.tones != `HBF_STUFF_N) && st_ff.ctrl[`HBF_C_EN] &&
      !st_ff.teof && !st_ff.txv |=> (st_ff.txs == hbf_pkg::TX_ABORT) &&
      st_ff.stat[`HBF_S_UND]
  ) else $error("underrun did not abort");

  rx_preset_a: assert property (
    rx_flag |=> (st_ff.rcrc == `HBF_CRC_INIT) && (st_ff.rxs == hbf_pkg::RX_FRAME)
  ) else $error("receive CRC not preset on delimiter");

  rx_abort_a: assert property (
    rx_abt && (st_ff.rxs == hbf_pkg::RX_FRAME) |=> !st_ff.rxv &&
      (st_ff.rxs == hbf_pkg::RX_HUNT) && st_ff.stat[`HBF_S_ABT]
  ) else $error("abort not handled");

  crc_count_a: assert property (
    rx_end && (st_ff.rcrc != `HBF_CRC_GOOD) && !cnt_clr |=>
      st_ff.ccnt == $past(st_ff.ccnt) + 16'h0001
  ) else $error("CRC error not counted");

  rx_good_a: assert property (
    rx_end && (st_ff.rcrc == `HBF_CRC_GOOD) |=> st_ff.stat[`HBF_S_EOF] ##1
      (st_ff.rbits == 3'd0)
  ) else $error("good frame not reported");

  tx_dch_a: assert property (
    tx_tick && (st_ff.txs == hbf_pkg::TX_IDLE) && st_ff.ctrl[`HBF_C_DCH] &&
      !st_ff.txv |=> st_ff.txs == hbf_pkg::TX_IDLE
  ) else $error("delimiter fill in D-channel mode");

  tx_fill_a: assert property (
    tx_tick && (st_ff.txs == hbf_pkg::TX_IDLE) && st_ff.ctrl[`HBF_C_EN] &&
      st_ff.ctrl[`HBF_C_FILL] && !st_ff.ctrl[`HBF_C_DCH]
      |=> st_ff.txs == hbf_pkg::TX_FLAG1
  ) else $error("flag fill not started");

  rx_resid_a: assert property (
    rx_end |=> st_ff.resid == $past(st_ff.rbits)
  ) else $error("residue count not kept");

  rx_drop_a: assert property (
    rx_end && (st_ff.rcrc != `HBF_CRC_GOOD) && st_ff.ctrl[`HBF_C_DISC] |=>
      !st_ff.rxv && st_ff.stat[`HBF_S_DROP] && st_ff.stat[`HBF_S_CRC]
  ) else $error("bad frame not dropped");

  rx_delete_a: assert property (
    rx_tick && !rx_bit && (st_ff.rones == `HBF_STUFF_N) |=> $stable(st_ff.rdl)
  ) else $error("stuffed zero kept");

  rx_flag_a: assert property (
    rx_flag && !(rx_end && (st_ff.rbits != 3'd0)) |=> $stable(st_ff.rxd)
  ) else $error("delimiter reached receive data");

  rx_open_a: assert property (
    rx_end |=> (st_ff.rxs == hbf_pkg::RX_FRAME) && !st_ff.rany && (st_ff.rdn == 3'd0)
  ) else $error("closing delimiter did not open next frame");

  rx_still_a: assert property (
    !rx_tick |=> $stable(st_ff.rcrc) && $stable(st_ff.rsh)
  ) else $error("receiver moved without link clock edge");
endmodule

// ==== core/hbf_cfg.svh ====
// Constants of the bit-level HDLC framer
// How it works
// - Frames open and close with delimiter 01111110
// - Transmitter makes both delimiters itself
// - One delimiter may close a frame and open the next
// - Receiver hunts delimiters at every bit and resyncs on each
// - Received delimiters never reach the receive data register
// - Address field is the 8 or 16 bits after opening delimiter
// - Control field is the 8 or 16 bits after the address
// - Leftover bits are right-aligned, count kept in residue register
// - Last 16 bits before closing delimiter are CCITT CRC-16
// - Receive CRC preset to all ones on each delimiter, transmit CRC on each opening delimiter
// - Transmitter sends complemented CRC over all frame data bits
// - Receiver flags a CRC error unless CRC residue equals F0B8
// - Received CRC bytes are passed on with the data
// - Optionally discard frames that fail the check
// - Every failing frame increments the CRC error counter
// - Test bit forces a wrong CRC on transmit
// - Transmitter inserts a zero after five ones inside a frame
// - Receiver deletes the zero following five ones
// - Abort is seven or more ones
// - Received abort flushes data and resumes hunting
// - Line is in-frame, flag fill or idle ones
// - D-channel mode never fills with delimiters
// - Bytes go out LSB first right after the opening delimiter
// - Control bit picks flag fill or mark fill between frames
// - Transmit underrun ends the frame with an abort
`ifndef HBF_CFG_SVH
`define HBF_CFG_SVH
`define HBF_FLAG 8'h7E
`define HBF_MARKS 8'hFF
`define HBF_CRC_INIT 16'hFFFF
`define HBF_CRC_POLY 16'h8408
`define HBF_CRC_GOOD 16'hF0B8
`define HBF_A_CTRL 8'h00
`define HBF_A_STAT 8'h04
`define HBF_A_TXD 8'h08
`define HBF_A_RXD 8'h0C
`define HBF_A_RES 8'h10
`define HBF_A_CNT 8'h14
`define HBF_C_EN 0
`define HBF_C_FILL 1
`define HBF_C_DCH 2
`define HBF_C_FCE 3
`define HBF_C_DISC 4
`define HBF_S_CRC 0
`define HBF_S_ABT 1
`define HBF_S_EOF 2
`define HBF_S_UND 3
`define HBF_S_DROP 4
`define HBF_S_TXB 8
`define HBF_S_RXF 9
`define HBF_S_TXV 10
`define HBF_D_VAL 8
`define HBF_STUFF_N 3'd5
`define HBF_ABT_N 3'd6
`define HBF_ONES_MAX 3'd7
`define HBF_BYTE_BITS 5'd8
`define HBF_CRC_BITS 5'd16
`define HBF_DLY 3'd7
`endif

// ==== core/hbf_pkg.sv ====
// Types of the bit-level HDLC framer
package hbf_pkg;
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_FLAG1 = 6'h02,
    TX_DATA = 6'h04,
    TX_CRC = 6'h08,
    TX_FLAG2 = 6'h10,
    TX_ABORT = 6'h20
  } hbf_tx_t;
  typedef enum logic [1:0] {
    RX_HUNT = 2'h1,
    RX_FRAME = 2'h2
  } hbf_rx_t;
  typedef struct packed {
    logic [2:0][2:0] syn;
    logic pend;
    logic wr;
    logic [7:0] addr;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic [4:0] ctrl;
    logic [4:0] stat;
    logic [8:0] txd;
    logic txv;
    logic [7:0] rxd;
    logic rxv;
    logic [2:0] resid;
    logic [15:0] ccnt;
    hbf_tx_t txs;
    logic [15:0] tsh;
    logic [4:0] tcnt;
    logic [2:0] tones;
    logic [15:0] tcrc;
    logic teof;
    logic tline;
    hbf_rx_t rxs;
    logic [6:0] rdl;
    logic [2:0] rdn;
    logic [7:0] rsh;
    logic [2:0] rbits;
    logic rany;
    logic [2:0] rones;
    logic [15:0] rcrc;
  } hbf_st_t;
endpackage

// ==== tb/hbf_station.sv ====
// Remote station model: link clocks, serial source and frame decoder
`timescale 1ns/1ns
module hbf_station (
  output logic tx_clk,
  output logic rx_clk,
  output logic rx_data,
  input wire logic tx_data,
  input wire logic tx_run
);
  bit rxq[$];
  bit fb[$];
  logic [15:0] got[$];
  logic [7:0] sh;
  int ones = 0;
  int flags = 0;
  bit inf = 0;
  function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? 16'h8408 : 16'h0000);
  endfunction
  initial begin
    rx_clk = 0;
    rx_data = 1;
    #5;
    forever begin
      #80;
      rx_clk = 0;
      if (rxq.size() != 0) begin
        rx_data = rxq.pop_front();
        #80;
        rx_clk = 1;
      end else begin
        rx_data = ~rx_data;
      end
    end
  end
  initial begin
    tx_clk = 0;
    #3;
    forever begin
      #80;
      tx_clk = tx_run ? ~tx_clk : 1'b0;
    end
  end
  always @(posedge tx_clk) begin
    logic [15:0] c;
    logic [7:0] v;
    sh = {tx_data, sh[7:1]};
    if (sh == 8'h7E) begin
      flags++;
      if (inf && fb.size() > 7) begin
        c = 16'hFFFF;
        repeat (7) void'(fb.pop_back());
        foreach (fb[i]) c = crc_step(c, fb[i]);
        for (int i = 0; i + 16 < fb.size(); i += 8) begin
          for (int j = 0; j < 8; j++) v[j] = fb[i + j];
          got.push_back({8'h00, v});
        end
        got.push_back(c == 16'hF0B8 ? 16'h0101 : 16'h0100);
      end
      fb.delete();
      inf = 1;
      ones = 0;
    end else begin
      if (tx_data) ones++;
      if (ones == 7 && inf) begin
        if (fb.size() >= 7) got.push_back(16'h0200);
        inf = 0;
      end else if (inf && !(tx_data == 0 && ones == 5)) begin
        fb.push_back(tx_data);
      end
      if (!tx_data) ones = 0;
    end
  end
endmodule

// ==== tb/hbf_framer_test.sv ====
// Self-checking bench for the HDLC framer
`timescale 1ns/1ns
module hbf_framer_test;
  typedef struct {string nm; logic [31:0] v;} hbf_exp_t;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, tx_run = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, tx_clk, rx_clk, rx_data, tx_data;
  int failures = 0, checks = 0, f0;
  hbf_exp_t exp_q[$];
  hbf_exp_t e;
  logic [31:0] got_q[$];
  logic [15:0] texp[$];
  logic [7:0] rxe[$];
  always #4 mclk = ~mclk;
  hbf_framer DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_clk_pin(tx_clk),
    .rx_clk_pin(rx_clk), .rx_data_pin(rx_data), .tx_data_pin(tx_data));
  hbf_station peer (.tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data(rx_data),
    .tx_data(tx_data), .tx_run(tx_run));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, want, seen);
    end
  endtask
  task automatic tally_and_finish(input bit hung);
    failures += hung;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (got_q.size() != 0) begin
      e = exp_q.pop_front();
      check(e.nm, got_q.pop_front(), e.v);
    end
    if (peer.got.size() != 0) begin
      check("tx line", {16'h0, peer.got.pop_front()}, {16'h0, texp.pop_front()});
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rdv = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
    if (n >= 50) tally_and_finish(1);
  endtask
  task automatic rd_exp(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] want);
    exp_q.push_back('{nm, want});
    bus(0, a, 32'h0);
    got_q.push_back(rdv & m);
  endtask
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin bus(0, 8'h04, 32'h0); n++; end while (rdv[b] !== v && n < 2000);
    if (n >= 2000) tally_and_finish(1);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (texp.size() != 0 && n < 20000) begin @(posedge mclk); n++; end
    if (n >= 20000) tally_and_finish(1);
  endtask
  task automatic tx_frame(input int n, input bit bad);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      texp.push_back({8'h00, v});
      wait_stat(10, 0);
      bus(1, 8'h08, {23'h0, i == n - 1, v});
    end
    texp.push_back(bad ? 16'h0100 : 16'h0101);
  endtask
  task automatic push_raw(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) peer.rxq.push_back(v[i]);
  endtask
  task automatic rx_frame(input int nb, input int ex, input bit bad);
    bit fr[$];
    logic [7:0] v;
    logic [15:0] c;
    int ones;
    c = 16'hFFFF;
    ones = 0;
    for (int i = 0; i < nb * 8 + ex; i++) fr.push_back(i < 8 ? 1'b1 : 1'($urandom));
    foreach (fr[i]) c = peer.crc_step(c, fr[i]);
    c = ~c ^ {15'h0, bad};
    for (int i = 0; i < 16; i++) fr.push_back(c[i]);
    for (int i = 0; i < fr.size(); i += 8) begin
      v = 8'h00;
      for (int j = 0; j < 8 && i + j < fr.size(); j++) v[j] = fr[i + j];
      rxe.push_back(v);
    end
    push_raw(8'h7E, 8);
    foreach (fr[i]) begin
      peer.rxq.push_back(fr[i]);
      ones = fr[i] ? ones + 1 : 0;
      if (ones == 5) begin
        peer.rxq.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic rx_collect();
    int n;
    while (rxe.size() != 0) begin
      n = 0;
      do begin bus(0, 8'h0C, 32'h0); n++; end while (rdv[8] !== 1'b1 && n < 3000);
      if (n >= 3000) tally_and_finish(1);
      exp_q.push_back('{"rx byte", {23'h0, 1'b1, rxe.pop_front()}});
      got_q.push_back(rdv);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    void'($urandom(32'h2B7F));
    for (int a = 0; a <= 32; a += 4) rd_exp("reg at reset", 8'(a), 32'hFFFFFFFF, 32'h0);
    tx_run <= 1;
    bus(1, 8'h00, 32'h03);
    tx_frame(3, 0);
    tx_frame(2, 0);
    drain();
    bus(1, 8'h00, 32'h0B);
    tx_frame(2, 1);
    drain();
    bus(1, 8'h00, 32'h03);
    f0 = peer.flags;
    repeat (400) @(posedge mclk);
    check("flag fill", 32'(peer.flags > f0), 32'h1);
    bus(1, 8'h08, 32'h55);
    texp.push_back(16'h0200);
    drain();
    rd_exp("underrun", 8'h04, 32'h8, 32'h8);
    bus(1, 8'h00, 32'h07);
    repeat (400) @(posedge mclk);
    f0 = peer.flags;
    tx_frame(1, 0);
    drain();
    repeat (800) @(posedge mclk);
    check("mark fill flags", 32'(peer.flags - f0), 32'h2);
    bus(1, 8'h04, 32'h1F);
    bus(1, 8'h00, 32'h00);
    push_raw(8'h05, 3);
    rx_frame(3, 0, 0);
    rx_frame(2, 3, 0);
    push_raw(8'h7E, 8);
    rx_collect();
    wait_stat(2, 1);
    rd_exp("residue", 8'h10, 32'h7, 32'h3);
    rd_exp("rx status", 8'h04, 32'h17, 32'h4);
    bus(1, 8'h04, 32'h1F);
    push_raw(8'h7E, 8);
    push_raw(8'h00, 8);
    push_raw(8'h00, 8);
    push_raw(8'hFF, 8);
    wait_stat(1, 1);
    rd_exp("rx after abort", 8'h0C, 32'h100, 32'h0);
    bus(1, 8'h04, 32'h1F);
    bus(1, 8'h00, 32'h10);
    rx_frame(2, 0, 1);
    push_raw(8'h7E, 8);
    rxe.delete();
    wait_stat(0, 1);
    rd_exp("bad frame status", 8'h04, 32'h17, 32'h11);
    rd_exp("crc count", 8'h14, 32'hFFFF, 32'h1);
    bus(1, 8'h14, 32'h0);
    rd_exp("count clear", 8'h14, 32'hFFFF, 32'h0);
    repeat (4) @(posedge mclk);
    tally_and_finish(0);
  end
endmodule
